// *** include/rsf_defines.svh ***
// Offsets, field positions, reset values and widths of the receiver
// status flag bank. Assumes a byte-wide register port.
//
// Overview of operation
// R1 - Q sub-code change sets change flag
// R2 - Lock-loss flag high unless decoder and loop locked
// R3 - Completed buffer transfer sets transfer flag
// R4 - Output sample slip or repeat sets slip flag
// R5 - Only unmasked flags raise the interrupt
// R6 - Slip only from receiver-fed slave port
// R7 - Single receiver-fed port is the monitored one
// R8 - Both ports receiver-fed: watch port A only
// R9 - Q sub-code CRC error sets CRC flag
// R10 - Slip register upper bits zero, writes ignored
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH

`define RSF_AW         8
`define RSF_DW         8
`define RSF_NEV        5
`define RSF_NSYNC      2

// Register offsets
`define RSF_OFF_STAT2  8'h14
`define RSF_OFF_STAT3  8'h15
`define RSF_OFF_MASK1  8'h16
`define RSF_OFF_MASK2  8'h17
`define RSF_OFF_ISTAT  8'h30

// Q sub-code byte window read after a change
`define RSF_QSUB_FIRST 8'h1F
`define RSF_QSUB_LAST  8'h28

// Event and flag bit positions
`define RSF_B_XFER     0
`define RSF_B_CRC      1
`define RSF_B_UNLOCK   2
`define RSF_B_CHANGE   3
`define RSF_B_SLIP     4
`define RSF_B_SLIP3    0

// Reset values
`define RSF_RST_MASK1  8'h00
`define RSF_RST_MASK2  1'b0
`define RSF_RST_ISTAT  5'h00
`define RSF_RST_RDATA  8'h00

`endif

// *** include/rsf_pkg.sv ***
// Types of the receiver status flag bank.
// Assumes rsf_defines.svh is on the include path.
`include "rsf_defines.svh"

package rsf_pkg;

   // Synchroniser stages for the lock levels
   typedef struct packed {
      logic [`RSF_NSYNC-1:0] s1;  // First stage
      logic [`RSF_NSYNC-1:0] s2;  // Second stage
   } rsf_sync_s;

   // Interrupt status and mask state
   typedef struct packed {
      logic [`RSF_NEV-1:0] istat;  // Sticky events
      logic [`RSF_DW-1:0]  mask1;  // Mask for four flags
      logic                mask2;  // Mask for slip flag
      logic                irq;    // Registered interrupt
   } rsf_irq_s;

   // Flag bank and read port state
   typedef struct packed {
      logic [`RSF_DW-1:0] rdata;   // Read data
      logic               sc_change;   // Sub-code change
      logic               sc_crc_err;  // Sub-code CRC error
      logic               xfer_done;   // Transfer complete
      logic               out_slip;    // Output slip
      logic               unlock;  // Lock loss
   } rsf_top_s;

endpackage : rsf_pkg

// *** include/rsf_if.sv ***
// Carrier between the flag bank and its interrupt unit.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defines.svh"

interface rsf_if;
   logic [`RSF_NEV-1:0] ev;     // Event pulses
   logic                clr_wr; // Write-one-to-clear strobe
   logic [`RSF_DW-1:0]  wdata;  // Write data
   logic                m1_wr;  // Mask 1 write
   logic                m2_wr;  // Mask 2 write
   logic [`RSF_NEV-1:0] istat;  // Sticky status
   logic [`RSF_DW-1:0]  mask1;  // Mask 1 value
   logic                mask2;  // Mask 2 value
   logic                irq;    // Interrupt level

   // Flag bank side
   modport ctl (output ev, clr_wr, wdata, m1_wr, m2_wr,
                input istat, mask1, mask2, irq);
   // Interrupt unit side
   modport irq_side (input ev, clr_wr, wdata, m1_wr, m2_wr,
                     output istat, mask1, mask2, irq);
endinterface : rsf_if

`default_nettype wire

// *** src/rsf_sync.sv ***
// Two-stage synchroniser bank for asynchronous level inputs.
// Assumes inputs are slow levels, not pulses.
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defines.svh"

module rsf_sync (
   input  wire logic                  clk_in,   // Register clock
   input  wire logic                  rstn_in,  // Async reset, low
   input  wire logic [`RSF_NSYNC-1:0] async_in, // Raw levels
   output logic      [`RSF_NSYNC-1:0] sync_out  // Synchronised levels
);
   rsf_pkg::rsf_sync_s q;  // Current stages
   rsf_pkg::rsf_sync_s d;  // Next stages

   // Shift raw level through two stages
   always_comb begin
      d    = q;
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   // Stage registers
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;
endmodule : rsf_sync

`default_nettype wire

// *** src/rsf_irq.sv ***
// Sticky interrupt status, masks and the interrupt level.
// Assumes event pulses and strobes arrive on clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defines.svh"

module rsf_irq (
   input  wire logic clk_in,  // Register clock
   input  wire logic rstn_in, // Async reset, low
   rsf_if.irq_side   bus      // Link to flag bank
);
   rsf_pkg::rsf_irq_s   q;    // Current state
   rsf_pkg::rsf_irq_s   d;    // Next state
   logic [`RSF_NEV-1:0] en;   // Per-event enables
   logic [`RSF_NEV-1:0] clr;  // Clear request

   // Next status, masks and interrupt
   always_comb begin
      d   = q;
      clr = bus.clr_wr ? bus.wdata[`RSF_NEV-1:0] : '0;
      // Set wins over a same-cycle clear
      d.istat = (q.istat & ~clr) | bus.ev;
      if (bus.m1_wr) begin
         d.mask1 = bus.wdata;
      end
      if (bus.m2_wr) begin
         d.mask2 = bus.wdata[0];
      end
      en = {d.mask2, d.mask1[`RSF_B_CHANGE:0]};
      // R5 mask gating
      d.irq = |(d.istat & en);
   end

   // State register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q.istat <= `RSF_RST_ISTAT;
         q.mask1 <= `RSF_RST_MASK1;
         q.mask2 <= `RSF_RST_MASK2;
         q.irq   <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign bus.istat = q.istat;
   assign bus.mask1 = q.mask1;
   assign bus.mask2 = q.mask2;
   assign bus.irq   = q.irq;

   // R5 masked flag stays quiet
   a_irq_mask_gate : assert property (@(posedge clk_in) disable iff (!rstn_in)
      q.irq == |(q.istat & {q.mask2, q.mask1[`RSF_B_CHANGE:0]})) // R5
      else $error("interrupt does not match masked status");
   a_event_sticks : assert property (@(posedge clk_in) disable iff (!rstn_in)
      bus.ev[0] |=> q.istat[0] ##1 (q.istat[0] || $past(bus.clr_wr))) // R5
      else $error("transfer event not held in status");
   cover_irq_rise : cover property (@(posedge clk_in) disable iff (!rstn_in)
      $rose(q.irq));
endmodule : rsf_irq

`default_nettype wire

// *** src/rsf_top.sv ***
// Receiver status flag bank: sub-code, lock, transfer and slip flags,
// their read port and the masked interrupt.
// Assumes event pulses come from logic on clk_in; lock levels are
// asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defines.svh"

module rsf_top (
   input  wire logic               clk_in,            // 200 MHz clock
   input  wire logic               rstn_in,           // Async reset, low
   input  wire logic [`RSF_AW-1:0] addr_in,           // Register address
   input  wire logic [`RSF_DW-1:0] wdata_in,          // Write data
   input  wire logic               wr_in,             // Write strobe
   input  wire logic               rd_in,             // Read strobe
   input  wire logic               qsub_change_in,    // Sub-code changed
   input  wire logic               qsub_crc_err_in,   // Sub-code CRC bad
   input  wire logic               xfer_done_in,      // Buffer copy done
   input  wire logic               frame_locked_in,   // Decoder lock, async
   input  wire logic               phase_locked_in,   // Loop lock, async
   input  wire logic               slip_a_in,         // Slip seen at port A
   input  wire logic               slip_b_in,         // Slip seen at port B
   input  wire logic               port_a_rx_src_in,  // Port A fed by receiver
   input  wire logic               port_b_rx_src_in,  // Port B fed by receiver
   input  wire logic               port_a_slave_in,   // Port A in slave mode
   input  wire logic               port_b_slave_in,   // Port B in slave mode
   output logic      [`RSF_DW-1:0] rdata_out,         // Read data
   output logic                    irq_out            // Interrupt, high
);

   // Address match, shared by read and write decode
   function automatic logic rsf_hit(input logic [`RSF_AW-1:0] a,
                                    input logic [`RSF_AW-1:0] o);
      rsf_hit = (a == o);
   endfunction : rsf_hit

   rsf_pkg::rsf_top_s     q;          // Current state
   rsf_pkg::rsf_top_s     d;          // Next state
   logic [`RSF_NSYNC-1:0] lock_s;     // Synchronised locks
   logic                  unlock_now; // Live lock loss
   logic                  sel_a;      // Port A monitored
   logic                  sel_b;      // Port B monitored
   logic                  slip_ev;    // Qualified slip event
   logic                  rd_stat2;   // Read of flag register
   logic                  rd_stat3;   // Read of slip register

   rsf_if ifc ();  // Link to interrupt unit

   // Lock levels cross into the register clock
   rsf_sync u_sync (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .async_in ({phase_locked_in, frame_locked_in}),
      .sync_out (lock_s)
   );

   // Sticky status, masks and interrupt level
   rsf_irq u_irq (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .bus     (ifc)
   );

   // R2 unlocked unless both locked
   assign unlock_now = ~(lock_s[0] & lock_s[1]);

   // R8 port A takes precedence
   assign sel_a = port_a_rx_src_in;
   // R7 port B only when alone
   assign sel_b = port_b_rx_src_in & ~port_a_rx_src_in;

   // R6 slave-mode receiver-fed port only
   assign slip_ev = (sel_a & port_a_slave_in & slip_a_in)
                  | (sel_b & port_b_slave_in & slip_b_in);

   // Read strobes that clear latched flags
   assign rd_stat2 = rd_in & rsf_hit(addr_in, `RSF_OFF_STAT2);
   assign rd_stat3 = rd_in & rsf_hit(addr_in, `RSF_OFF_STAT3);

   // Events and strobes toward the interrupt unit
   always_comb begin
      ifc.ev                   = '0;
      ifc.ev[`RSF_B_XFER]      = xfer_done_in;
      ifc.ev[`RSF_B_CRC]       = qsub_crc_err_in;
      // Lock loss counts once, on its rising edge
      ifc.ev[`RSF_B_UNLOCK]    = unlock_now & ~q.unlock;
      ifc.ev[`RSF_B_CHANGE]    = qsub_change_in;
      ifc.ev[`RSF_B_SLIP]      = slip_ev;
      ifc.wdata                = wdata_in;
      ifc.clr_wr               = wr_in & rsf_hit(addr_in, `RSF_OFF_ISTAT);
      ifc.m1_wr                = wr_in & rsf_hit(addr_in, `RSF_OFF_MASK1);
      ifc.m2_wr                = wr_in & rsf_hit(addr_in, `RSF_OFF_MASK2);
   end

   // Flag updates and read mux
   always_comb begin
      d = q;
      // R1 change flag, read clears
      d.sc_change  = qsub_change_in | (q.sc_change & ~rd_stat2);
      // R9 CRC flag, read clears
      d.sc_crc_err = qsub_crc_err_in | (q.sc_crc_err & ~rd_stat2);
      // R3 transfer flag, read clears
      d.xfer_done  = xfer_done_in | (q.xfer_done & ~rd_stat2);
      // R4 slip flag, read clears
      d.out_slip   = slip_ev | (q.out_slip & ~rd_stat3);
      // R2 lock loss follows live level
      d.unlock = unlock_now;
      d.rdata  = `RSF_RST_RDATA;
      if (rd_in) begin
         case (addr_in)
            // Flag register, upper bits unused
            `RSF_OFF_STAT2: begin
               d.rdata = {4'h0, q.sc_change, q.unlock, q.sc_crc_err, q.xfer_done};
            end
            // R10 upper bits read zero
            `RSF_OFF_STAT3: begin
               d.rdata = {7'h00, q.out_slip};
            end
            // Mask for four flags
            `RSF_OFF_MASK1: begin
               d.rdata = ifc.mask1;
            end
            // Mask for slip flag
            `RSF_OFF_MASK2: begin
               d.rdata = {7'h00, ifc.mask2};
            end
            // Sticky interrupt status
            `RSF_OFF_ISTAT: begin
               d.rdata = {3'h0, ifc.istat};
            end
            // Unmapped reads as zero
            default: begin
               d.rdata = `RSF_RST_RDATA;
            end
         endcase
      end
   end

   // State register; writes to the slip register are not decoded
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q.rdata  <= `RSF_RST_RDATA;
         q.sc_change  <= 1'b0;
         q.sc_crc_err <= 1'b0;
         q.xfer_done  <= 1'b0;
         q.out_slip   <= 1'b0;
         // Unlocked until the locks are seen
         q.unlock <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops
   assign rdata_out = q.rdata;
   assign irq_out   = ifc.irq;

   // Checks on the flag bank

   // R1 change sets flag
   a_change_set : assert property (@(posedge clk_in) disable iff (!rstn_in)
      qsub_change_in |=> q.sc_change) // R1
      else $error("sub-code change flag not set");

   // R2 loss shows one cycle later
   a_unlock_high : assert property (@(posedge clk_in) disable iff (!rstn_in)
      !(lock_s[0] && lock_s[1]) |=> q.unlock) // R2
      else $error("lock loss flag low while unlocked");

   a_unlock_low : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (lock_s[0] && lock_s[1]) |=> !q.unlock) // R2
      else $error("lock loss flag high while locked");

   // R3 transfer sets flag
   a_xfer_set : assert property (@(posedge clk_in) disable iff (!rstn_in)
      xfer_done_in |=> q.xfer_done) // R3
      else $error("transfer flag not set");

   // R4 slip flag read back
   a_slip_read : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (q.out_slip && rd_in && addr_in == `RSF_OFF_STAT3) |=> rdata_out == 8'h01) // R4
      else $error("slip flag not read back");

   // R6 slip needs slave port
   a_slip_slave : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (!q.out_slip ##1 q.out_slip) |-> $past((port_a_rx_src_in && port_a_slave_in)
                                    || (port_b_rx_src_in && port_b_slave_in))) // R6
      else $error("slip raised without receiver-fed slave port");

   // R7 lone port B monitored
   a_slip_port_b : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (!port_a_rx_src_in && port_b_rx_src_in && port_b_slave_in && slip_b_in)
      |=> q.out_slip) // R7
      else $error("slip on lone port B missed");

   // R8 port B ignored with A
   a_slip_port_a : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (port_a_rx_src_in && port_b_rx_src_in && slip_b_in && !slip_a_in
       && !q.out_slip) |=> !q.out_slip) // R8
      else $error("port B slip counted while port A fed");

   // R9 CRC error sets flag
   a_crc_set : assert property (@(posedge clk_in) disable iff (!rstn_in)
      qsub_crc_err_in |=> q.sc_crc_err ##1 (q.sc_crc_err || $past(rd_stat2))) // R9
      else $error("sub-code CRC flag not held");

   // R10 upper bits are zero
   a_stat3_zero : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (rd_in && addr_in == `RSF_OFF_STAT3) |=> rdata_out[7:1] == 7'h00) // R10
      else $error("slip register upper bits not zero");

   // R10 write leaves flag alone
   a_stat3_nowrite : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (wr_in && addr_in == `RSF_OFF_STAT3 && q.out_slip && !rd_in) |=> q.out_slip) // R10
      else $error("write changed slip register");

   // Read data stand one cycle only
   a_read_once : assert property (@(posedge clk_in) disable iff (!rstn_in)
      !rd_in |=> rdata_out == 8'h00)
      else $error("read data outside read answer cycle");

   // R1 read without new change clears flag
   a_change_clear : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (rd_stat2 && !qsub_change_in) |=> !q.sc_change) // R1
      else $error("sub-code change flag not cleared by read");

   // R4 read without new slip clears flag
   a_slip_clear : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (rd_stat3 && !slip_ev) |=> !q.out_slip) // R4
      else $error("slip flag not cleared by read");

   // R2 lock loss rise reaches status
   a_unlock_event : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (unlock_now && !q.unlock) |=> ifc.istat[`RSF_B_UNLOCK]) // R2
      else $error("lock loss event not in interrupt status");

   // R9 CRC error reaches status
   a_crc_event : assert property (@(posedge clk_in) disable iff (!rstn_in)
      qsub_crc_err_in |=> ifc.istat[`RSF_B_CRC]) // R9
      else $error("CRC event not in interrupt status");

   // R4 qualified slip reaches status
   a_slip_event : assert property (@(posedge clk_in) disable iff (!rstn_in)
      slip_ev |=> ifc.istat[`RSF_B_SLIP]) // R4
      else $error("slip event not in interrupt status");

   // R5 all masked keeps interrupt low
   a_irq_all_masked : assert property (@(posedge clk_in) disable iff (!rstn_in)
      (ifc.mask1 == 8'h00 && !ifc.mask2 && !ifc.m1_wr && !ifc.m2_wr)
      |=> !irq_out) // R5
      else $error("interrupt raised with every flag masked");

   // Flag register upper bits read zero
   a_stat2_upper : assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_stat2 |=> rdata_out[7:4] == 4'h0)
      else $error("flag register upper bits not zero");

   // Main scenarios
   cover_slip_both : cover property (@(posedge clk_in) disable iff (!rstn_in)
      port_a_rx_src_in && port_b_rx_src_in && slip_ev);

   cover_read_clear : cover property (@(posedge clk_in) disable iff (!rstn_in)
      q.sc_change && rd_stat2 ##1 !q.sc_change);

   cover_slip_port_b : cover property (@(posedge clk_in) disable iff (!rstn_in)
      sel_b && slip_ev);

   cover_irq_unlock : cover property (@(posedge clk_in) disable iff (!rstn_in)
      q.unlock ##1 irq_out);

endmodule : rsf_top

`default_nettype wire

// *** test/receiver_status_flags_tb.sv ***
// Self-checking bench of the receiver status flag bank: reset values,
// lock loss, event flags, slip port selection and the masked interrupt.
// Assumes rsf_defines.svh on the include path and the top rsf_top.
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defines.svh"

// Compare one design value with its expected value
`define CHK(nm, exp, got) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      num_errors++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
   end \
end

module receiver_status_flags_tb;
   logic                clk_in;       // Register clock
   logic                rstn_in;      // Reset, low
   logic [`RSF_AW-1:0]  addr_in;      // Address
   logic [`RSF_DW-1:0]  wdata_in;     // Write data
   logic                wr_in;        // Write strobe
   logic                rd_in;        // Read strobe
   logic [2:0]          ev;           // Change, CRC, transfer pulses
   logic                frame_lk;     // Decoder lock level
   logic                phase_lk;     // Loop lock level
   logic [1:0]          slip;         // Slip pulses B, A
   logic [1:0]          src;          // Receiver-fed B, A
   logic [1:0]          slv;          // Slave mode B, A
   logic [`RSF_DW-1:0]  rdata_out;    // Read data
   logic                irq_out;      // Interrupt
   int                  num_errors;   // Mismatch count
   int                  n_tests;      // Comparison count
   logic [`RSF_DW-1:0]  d;            // Last read value

   // Device under test
   rsf_top dut (
      .clk_in           (clk_in),
      .rstn_in          (rstn_in),
      .addr_in          (addr_in),
      .wdata_in         (wdata_in),
      .wr_in            (wr_in),
      .rd_in            (rd_in),
      .qsub_change_in   (ev[2]),
      .qsub_crc_err_in  (ev[1]),
      .xfer_done_in     (ev[0]),
      .frame_locked_in  (frame_lk),
      .phase_locked_in  (phase_lk),
      .slip_a_in        (slip[0]),
      .slip_b_in        (slip[1]),
      .port_a_rx_src_in (src[0]),
      .port_b_rx_src_in (src[1]),
      .port_a_slave_in  (slv[0]),
      .port_b_slave_in  (slv[1]),
      .rdata_out        (rdata_out),
      .irq_out          (irq_out)
   );

   // Free running 200 MHz clock
   always #2.5 clk_in = ~clk_in;

   // Verdict and end of run
   task automatic wrap_up();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   // One-cycle read; data sampled in the following cycle
   task automatic rd(input logic [`RSF_AW-1:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1 d = rdata_out;
   endtask : rd

   // One-cycle write
   task automatic wr(input logic [`RSF_AW-1:0] a, input logic [`RSF_DW-1:0] v);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= v;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
      #1;
   endtask : wr

   // One-cycle event pulse on the chosen inputs
   task automatic pulse(input logic [2:0] e, input logic [1:0] s);
      @(posedge clk_in);
      ev   <= e;
      slip <= s;
      @(posedge clk_in);
      ev   <= 3'h0;
      slip <= 2'h0;
      #1;
   endtask : pulse

   // Values after reset, unmapped and read-only places
   task automatic t_reset();
      `CHK("irq after reset", 1'b0, irq_out)
      rd(`RSF_OFF_STAT3);
      `CHK("slip reg reset", 8'h00, d)
      rd(`RSF_OFF_STAT2);
      `CHK("flags unlocked", 8'h04, d)
      wr(`RSF_OFF_STAT3, 8'hFF);
      rd(`RSF_OFF_STAT3);
      `CHK("slip reg write ignored", 8'h00, d)
      rd(8'h5A);
      `CHK("unmapped read", 8'h00, d)
   endtask : t_reset

   // Lock loss clears only with both locks
   task automatic t_lock();
      frame_lk <= 1'b1;
      repeat (4) @(posedge clk_in);
      rd(`RSF_OFF_STAT2);
      `CHK("one lock only", 8'h04, d)
      phase_lk <= 1'b1;
      repeat (4) @(posedge clk_in);
      rd(`RSF_OFF_STAT2);
      `CHK("both locked", 8'h00, d)
      frame_lk <= 1'b0;
      repeat (4) @(posedge clk_in);
      rd(`RSF_OFF_STAT2);
      `CHK("decoder lost", 8'h04, d)
      frame_lk <= 1'b1;
      repeat (4) @(posedge clk_in);
   endtask : t_lock

   // Each event sets its flag; a read clears it
   task automatic t_events();
      logic [2:0] e;
      for (int i = 0; i < 4; i++) begin
         e = (i == 3) ? 3'h7 : 3'(1 << i);
         pulse(e, 2'h0);
         rd(`RSF_OFF_STAT2);
         `CHK("event flags", {4'h0, e[2], 1'b0, e[1], e[0]}, d)
         rd(`RSF_OFF_STAT2);
         `CHK("flags cleared", 8'h00, d)
      end
   endtask : t_events

   // Slip source table: src, slave, slip, expected flag
   task automatic t_slip();
      logic [6:0] tbl [7];
      tbl = '{7'b01_01_01_1, 7'b01_00_01_0, 7'b10_10_10_1, 7'b10_10_01_0,
              7'b11_11_10_0, 7'b11_11_01_1, 7'b00_11_11_0};
      for (int i = 0; i < 7; i++) begin
         @(posedge clk_in);
         src <= tbl[i][6:5];
         slv <= tbl[i][4:3];
         pulse(3'h0, tbl[i][2:1]);
         rd(`RSF_OFF_STAT3);
         `CHK("slip flag", {7'h00, tbl[i][0]}, d)
         rd(`RSF_OFF_STAT3);
         `CHK("slip cleared", 8'h00, d)
      end
   endtask : t_slip

   // Masked events stay quiet; unmasking and clearing drive the level
   task automatic t_irq();
      wr(`RSF_OFF_ISTAT, 8'h1F);
      wr(`RSF_OFF_MASK1, 8'h00);
      pulse(3'h1, 2'h0);
      `CHK("masked transfer irq", 1'b0, irq_out)
      rd(`RSF_OFF_ISTAT);
      `CHK("sticky status", 8'h01, d)
      wr(`RSF_OFF_MASK1, 8'h01);
      `CHK("unmasked irq", 1'b1, irq_out)
      wr(`RSF_OFF_ISTAT, 8'h01);
      `CHK("irq cleared", 1'b0, irq_out)
      pulse(3'h4, 2'h0);
      `CHK("change masked", 1'b0, irq_out)
      wr(`RSF_OFF_MASK1, 8'h08);
      `CHK("change irq", 1'b1, irq_out)
      wr(`RSF_OFF_ISTAT, 8'h08);
      wr(`RSF_OFF_MASK2, 8'h01);
      src <= 2'b11;
      slv <= 2'b11;
      pulse(3'h0, 2'b10);
      `CHK("port B slip ignored", 1'b0, irq_out)
      pulse(3'h0, 2'b01);
      `CHK("slip irq", 1'b1, irq_out)
      wr(`RSF_OFF_ISTAT, 8'h10);
      `CHK("slip irq cleared", 1'b0, irq_out)
   endtask : t_irq

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_in);
      num_errors++;
      wrap_up();
   end

   // Main sequence
   initial begin
      clk_in     = 1'b0;
      rstn_in    = 1'b0;
      addr_in    = 8'h00;
      wdata_in   = 8'h00;
      wr_in      = 1'b0;
      rd_in      = 1'b0;
      ev         = 3'h0;
      frame_lk   = 1'b0;
      phase_lk   = 1'b0;
      slip       = 2'h0;
      src        = 2'h0;
      slv        = 2'h0;
      num_errors = 0;
      n_tests    = 0;
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      #1;
      t_reset();
      t_lock();
      t_events();
      t_slip();
      t_irq();
      wrap_up();
   end
endmodule : receiver_status_flags_tb

`default_nettype wire
